// ### rtl/ftt_defs.svh
// Purpose: named constants of the frame trigger timing block
// Assumes: 250 MHz clock, 32-bit register port with byte addresses
// Notes: definitions only, no logic
`ifndef FTT_DEFS_SVH
`define FTT_DEFS_SVH

// ****************************************
// timing
// ****************************************
`define FTT_CLK_HZ 250000000
`define FTT_T1_MS 16
`define FTT_T1_CYC (`FTT_CLK_HZ / 1000 * `FTT_T1_MS)
`define FTT_T3_NS 15800
`define FTT_T3_CYC ((`FTT_T3_NS * (`FTT_CLK_HZ / 1000000) + 999) / 1000)
`define FTT_TRIG_MIN_US 50
`define FTT_TRIG_MIN_CYC (`FTT_TRIG_MIN_US * (`FTT_CLK_HZ / 1000000))
`define FTT_RATE_RST 8'h3d

// ****************************************
// register offsets and fields
// ****************************************
`define FTT_A_CTRL 8'h00
`define FTT_A_RATE 8'h04
`define FTT_A_TEST 8'h08
`define FTT_A_STAT 8'h0c
`define FTT_A_ISTAT 8'h10
`define FTT_A_IEN 8'h14
`define FTT_A_ICLR 8'h18
`define FTT_A_FCNT 8'h1c
`define FTT_LBL_BASE 8'h40
`define FTT_LBL_MASK 8'hc0
`define FTT_LBL_IDX 5:2
`define FTT_LBL_WORDS 16
`define FTT_CTRL_RST 4'h8
`define FTT_B_STREAM 0
`define FTT_B_EVT 1
`define FTT_B_RAND 2
`define FTT_B_TPOL 3
`define FTT_I_DONE 0
`define FTT_I_REJ 1
`define FTT_I_DROP 2
`define FTT_EV_TEST 2'h1
`define FTT_EV_FRAME 2'h2

`endif

// ### rtl/ftt_pkg.sv
// Purpose: shared types of the frame trigger timing block
// Assumes: nothing
// Notes: constants live in ftt_defs.svh
package ftt_pkg;
    typedef enum logic [1:0] {st_idle, st_armed, st_delay, st_read} ftt_state_e;
endpackage

// ### rtl/ftt_lbl_if.sv
// Purpose: port between the register logic and the label store
// Assumes: one word per access
// Notes: read is combinational from the array
interface ftt_lbl_if;
    logic wr;
    logic [3:0] idx;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport ctrl(output wr, output idx, output wdata, input rdata);
    modport store(input wr, input idx, input wdata, output rdata);
endinterface

// ### rtl/ftt_label_store.sv
// Purpose: user label string storage
// Assumes: written one word at a time
// Notes: array has no reset so contents survive a block reset
`include "ftt_defs.svh"
module ftt_label_store (
    input wire logic clock,
    ftt_lbl_if.store lbl
);
    logic [31:0] mem [0:`FTT_LBL_WORDS-1];

    // ****************************************
    // storage
    // ****************************************
    // write port, contents kept through reset
    always_ff @(posedge clock) begin
        if (lbl.wr) begin
            mem[lbl.idx] <= lbl.wdata;
        end
    end

    // read port
    assign lbl.rdata = mem[lbl.idx];
endmodule

// ### rtl/ftt_trig_qual.sv
// Purpose: qualify the external trigger level into one pulse
// Assumes: trigger input synchronous to clock
// Notes: a level must stay active for the minimum width to count
`include "ftt_defs.svh"
module ftt_trig_qual #(
    parameter logic [13:0] MIN_CYC = 14'(`FTT_TRIG_MIN_CYC)
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic trig_in,
    input wire logic active_low,
    output logic trig_pulse
);
    logic [13:0] cnt;
    logic fired;

    // polarity select and width reached
    wire act = trig_in ^ active_low;
    wire full = cnt == MIN_CYC - 14'h1;

    // ****************************************
    // width filter
    // ****************************************
    // short glitches restart the count, one pulse per level
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 14'h0;
            fired <= 1'b0;
            trig_pulse <= 1'b0;
        end else begin
            trig_pulse <= act && full && !fired;
            if (!act) begin
                cnt <= 14'h0;
                fired <= 1'b0;
            end else if (full) begin
                fired <= 1'b1;
            end else begin
                cnt <= cnt + 14'h1;
            end
        end
    end
endmodule

// ### rtl/ftt_frame_timing.sv
// Purpose: frame timing, trigger acceptance and stream control
// Assumes: host keeps bulk_ready high for full timing; sync inputs
// Notes: register port, one level interrupt, event packet request port
// Functional notes
// - image words leave to the host over the bulk valid/ready port
// - frame timing holds only while the host never stalls the bulk port
// - free-running frame period is one over the configured rate, default 61
// - every readout lasts the fixed interval of 16 ms in both modes
// - trigger to readout start delay is 15.8 us
// - triggers arriving outside the armed state are refused
// - stream control opens and closes the image stream channel
// - event control enables frame event packets to the host
// - each test event write sends one test event packet, but a write while one is still pending merges into it
// - user label words are kept and readable and writable by host
//
// Chosen here: the placing of the registers and the plain strobed port.
`include "ftt_defs.svh"
module ftt_frame_timing #(
    parameter logic [22:0] T1_CYC = 23'(`FTT_T1_CYC),
    parameter logic [13:0] TRIG_MIN_CYC = 14'(`FTT_TRIG_MIN_CYC),
    parameter logic [27:0] CLK_HZ = 28'(`FTT_CLK_HZ)
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic trig_in,
    output logic trigger_wait,
    output logic bulk_valid,
    output logic [31:0] bulk_data,
    output logic bulk_last,
    input wire logic bulk_ready,
    output logic event_valid,
    output logic [1:0] event_code,
    input wire logic event_ready,
    output logic irq
);
    localparam logic [11:0] T3_CYC = 12'(`FTT_T3_CYC);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    ftt_pkg::ftt_state_e state, next_state;
    logic [3:0] ctrl;
    logic [7:0] rate;
    logic [2:0] irq_stat, irq_en;
    logic [15:0] fcount;
    logic [27:0] acc;
    logic [11:0] dly_cnt;
    logic [22:0] rd_cnt;
    logic test_pend, frame_pend;
    logic trig_pulse;
    logic [31:0] next_rdata;
    ftt_lbl_if lbl();

    // ****************************************
    // register decode
    // ****************************************
    wire wr_ctrl = reg_wr && hit(reg_addr, `FTT_A_CTRL);
    wire wr_rate = reg_wr && hit(reg_addr, `FTT_A_RATE);
    wire wr_test = reg_wr && hit(reg_addr, `FTT_A_TEST);
    wire wr_ien = reg_wr && hit(reg_addr, `FTT_A_IEN);
    wire wr_iclr = reg_wr && hit(reg_addr, `FTT_A_ICLR);
    wire lbl_sel = (reg_addr & `FTT_LBL_MASK) == `FTT_LBL_BASE;
    wire stream_channel_open = ctrl[`FTT_B_STREAM];
    wire event_notify_on = ctrl[`FTT_B_EVT];
    wire rand_mode = ctrl[`FTT_B_RAND];

    // label store access
    assign lbl.wr = reg_wr && lbl_sel;
    assign lbl.idx = reg_addr[`FTT_LBL_IDX];
    assign lbl.wdata = reg_wdata;

    ftt_label_store u_label (
        .clock(clock),
        .lbl(lbl.store)
    );

    ftt_trig_qual #(.MIN_CYC(TRIG_MIN_CYC)) u_trig (
        .clock(clock),
        .reset_n(reset_n),
        .trig_in(trig_in),
        .active_low(ctrl[`FTT_B_TPOL]),
        .trig_pulse(trig_pulse)
    );

    // ****************************************
    // frame rate generator
    // ****************************************
    // adds the rate each cycle, one frame per clock-rate worth
    wire free_run = stream_channel_open && !rand_mode;
    wire [27:0] acc_sum = 28'(acc + 28'(rate));
    wire frame_tick = free_run && acc_sum >= CLK_HZ;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            acc <= 28'h0;
        end else if (!free_run) begin
            acc <= 28'h0;
        end else begin
            acc <= frame_tick ? 28'(acc_sum - CLK_HZ) : acc_sum;
        end
    end

    // ****************************************
    // frame sequencer
    // ****************************************
    // readout advances when the output word is free or taken, so a stall stretches it
    wire word_go = state == ftt_pkg::st_read && (!bulk_valid || bulk_ready);
    wire last_go = word_go && rd_cnt == T1_CYC - 23'h1;
    wire dly_done = dly_cnt == T3_CYC - 12'h1;
    wire trig_take = state == ftt_pkg::st_armed && trig_pulse;
    wire trig_rej = trig_pulse && rand_mode && state != ftt_pkg::st_armed;
    wire drop = frame_tick && state != ftt_pkg::st_idle;

    // next state
    always_comb begin
        next_state = state;
        case (state)
            ftt_pkg::st_idle: begin
                if (stream_channel_open && rand_mode) begin
                    next_state = ftt_pkg::st_armed;
                end else if (frame_tick) begin
                    next_state = ftt_pkg::st_read;
                end
            end
            ftt_pkg::st_armed: begin
                if (!stream_channel_open || !rand_mode) begin
                    next_state = ftt_pkg::st_idle;
                end else if (trig_pulse) begin
                    next_state = ftt_pkg::st_delay;
                end
            end
            ftt_pkg::st_delay: begin
                if (dly_done) begin
                    next_state = ftt_pkg::st_read;
                end
            end
            default: begin
                if (last_go) begin
                    next_state = stream_channel_open && rand_mode ? ftt_pkg::st_armed : ftt_pkg::st_idle;
                end
            end
        endcase
    end

    // state and trigger wait, wait low from acceptance to readout end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= ftt_pkg::st_idle;
            trigger_wait <= 1'b0;
        end else begin
            state <= next_state;
            trigger_wait <= next_state == ftt_pkg::st_armed;
        end
    end

    // trigger delay and readout counters
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dly_cnt <= 12'h0;
            rd_cnt <= 23'h0;
        end else begin
            dly_cnt <= state == ftt_pkg::st_delay ? dly_cnt + 12'h1 : 12'h0;
            if (state != ftt_pkg::st_read || last_go) begin
                rd_cnt <= 23'h0;
            end else if (word_go) begin
                rd_cnt <= rd_cnt + 23'h1;
            end
        end
    end

    // ****************************************
    // bulk stream output
    // ****************************************
    // words are withheld while the channel is closed
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bulk_valid <= 1'b0;
            bulk_data <= 32'h0;
            bulk_last <= 1'b0;
        end else if (word_go) begin
            bulk_valid <= stream_channel_open;
            bulk_data <= {fcount, rd_cnt[15:0]};
            bulk_last <= last_go;
        end else if (bulk_ready) begin
            bulk_valid <= 1'b0;
            bulk_last <= 1'b0;
        end
    end

    // frame counter, counts completed readouts
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fcount <= 16'h0;
        end else if (last_go) begin
            fcount <= fcount + 16'h1;
        end
    end

    // ****************************************
    // event packets
    // ****************************************
    // test events take priority; set wins over the clear on a load
    wire ev_load = !event_valid || event_ready;
    wire frame_set = event_notify_on && state != ftt_pkg::st_read && next_state == ftt_pkg::st_read;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            test_pend <= 1'b0;
            frame_pend <= 1'b0;
            event_valid <= 1'b0;
            event_code <= 2'h0;
        end else begin
            test_pend <= wr_test || (test_pend && !ev_load);
            frame_pend <= frame_set || (frame_pend && !(ev_load && !test_pend));
            if (ev_load) begin
                event_valid <= test_pend || frame_pend;
                event_code <= test_pend ? `FTT_EV_TEST : `FTT_EV_FRAME;
            end
        end
    end

    // ****************************************
    // control registers and interrupt
    // ****************************************
    wire [2:0] ev_set = {drop, trig_rej, last_go};

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= `FTT_CTRL_RST;
            rate <= `FTT_RATE_RST;
            irq_en <= 3'h0;
            irq_stat <= 3'h0;
            irq <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl <= reg_wdata[3:0];
            if (wr_rate) rate <= reg_wdata[7:0];
            if (wr_ien) irq_en <= reg_wdata[2:0];
            irq_stat <= ev_set | (irq_stat & ~(wr_iclr ? reg_wdata[2:0] : 3'h0));
            irq <= |(irq_stat & irq_en);
        end
    end

    // read mux, unmapped and write-only offsets read zero
    always_comb begin
        if (lbl_sel) begin
            next_rdata = lbl.rdata;
        end else if (hit(reg_addr, `FTT_A_CTRL)) begin
            next_rdata = {28'h0, ctrl};
        end else if (hit(reg_addr, `FTT_A_RATE)) begin
            next_rdata = {24'h0, rate};
        end else if (hit(reg_addr, `FTT_A_STAT)) begin
            next_rdata = {27'h0, trigger_wait, bulk_valid, event_valid, state};
        end else if (hit(reg_addr, `FTT_A_ISTAT)) begin
            next_rdata = {29'h0, irq_stat};
        end else if (hit(reg_addr, `FTT_A_IEN)) begin
            next_rdata = {29'h0, irq_en};
        end else if (hit(reg_addr, `FTT_A_FCNT)) begin
            next_rdata = {16'h0, fcount};
        end else begin
            next_rdata = 32'h0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 32'h0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    property p_bulk_hold;
        bulk_valid && !bulk_ready |=> bulk_valid && $stable(bulk_data);
    endproperty
    a_bulk_hold: assert property (p_bulk_hold) else $error("bulk word dropped");

    property p_stall;
        state == ftt_pkg::st_read && bulk_valid && !bulk_ready |=> $stable(rd_cnt);
    endproperty
    a_stall: assert property (p_stall) else $error("readout ran during stall");

    property p_rate;
        state == ftt_pkg::st_idle && free_run && frame_tick |=> state == ftt_pkg::st_read;
    endproperty
    a_rate: assert property (p_rate) else $error("frame tick ignored");

    property p_t1;
        $fell(state == ftt_pkg::st_read) |-> $past(rd_cnt) == T1_CYC - 23'h1 && bulk_last;
    endproperty
    a_t1: assert property (p_t1) else $error("readout length wrong");

    property p_t3;
        state == ftt_pkg::st_read && $past(state) == ftt_pkg::st_delay |-> $past(dly_cnt) == T3_CYC - 12'h1;
    endproperty
    a_t3: assert property (p_t3) else $error("trigger delay wrong");

    property p_reject;
        trig_pulse && rand_mode && state != ftt_pkg::st_armed |=>
            irq_stat[`FTT_I_REJ] && (state != ftt_pkg::st_delay || $past(state) == ftt_pkg::st_delay);
    endproperty
    a_reject: assert property (p_reject) else $error("overlap trigger taken");

    property p_wait;
        trig_take |=> !trigger_wait [*2];
    endproperty
    a_wait: assert property (p_wait) else $error("wait high after accept");

    property p_wait_state;
        trigger_wait |-> state == ftt_pkg::st_armed && $past(rand_mode);
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("wait high while busy");

    property p_stream;
        !stream_channel_open && state == ftt_pkg::st_idle |=> state == ftt_pkg::st_idle && !$rose(bulk_valid);
    endproperty
    a_stream: assert property (p_stream) else $error("frame on closed channel");

    property p_test;
        wr_test && event_valid && !event_ready |=> test_pend ##1 test_pend || event_code == `FTT_EV_TEST;
    endproperty
    a_test: assert property (p_test) else $error("test event lost");

    property p_evt;
        $rose(frame_pend) |-> $past(event_notify_on);
    endproperty
    a_evt: assert property (p_evt) else $error("frame event while disabled");
endmodule

// ### testbench/ftt_host_model.sv
// Purpose: far side model: host sink for image words and events, external trigger source
// Assumes: trigger polarity given by the bench matches the block's setting
// Notes: rude makes the source ignore trigger wait on purpose
module ftt_host_model (
    input wire logic clock,
    input wire logic fire,
    input wire logic rude,
    input wire logic active_low,
    input wire logic [15:0] width,
    input wire logic trigger_wait,
    output logic trig_in,
    input wire logic stall,
    output logic bulk_ready,
    input wire logic slow,
    input wire logic event_valid,
    output logic event_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic act = 1'b0;
    logic [1:0] ev_wait = 2'h0;

    // ****************************************
    // host side
    // ****************************************
    // host drains image words unless the bench asks for a stall
    assign bulk_ready = ~stall;
    // events are taken at once, or after three cycles when slow
    assign event_ready = event_valid && (!slow || ev_wait == 2'h3);
    always @(posedge clock) begin
        ev_wait <= (event_valid && !event_ready) ? ev_wait + 2'h1 : 2'h0;
    end

    // ****************************************
    // trigger source
    // ****************************************
    // line idles inactive in the chosen polarity
    assign trig_in = active_low ? ~act : act;
    // one pulse per fire request
    always begin
        @(posedge clock);
        if (fire) begin
            while (!rude && trigger_wait !== 1'b1) @(posedge clock);
            act <= 1'b1;
            repeat (width) @(posedge clock);
            act <= 1'b0;
            repeat (16) @(posedge clock);
        end
    end
endmodule

// ### testbench/test_frame_trigger_timing.sv
// Purpose: self-checking bench of the frame trigger timing block
// Assumes: short frame and trigger width parameters, stream words always acknowledged unless stalled
// Notes: expectations come from the parameters set here
`include "ftt_defs.svh"
module test_frame_trigger_timing;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int T1 = 64;
    localparam int TMIN = 8;
    localparam int HZ = 8000;
    localparam int T3 = 3950;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, bulk_data;
    logic [1:0] event_code;
    logic trig_in, trigger_wait, bulk_valid, bulk_last, bulk_ready, event_valid, event_ready, irq;
    logic fire = 1'b0, rude = 1'b0, stall = 1'b0, slow = 1'b0, stall_en = 1'b0;
    int bad_count = 0, n_checks = 0, seed = 80, cyc = 0, words = 0, exp_idx = 0;
    int last_start = 0, period = 0, n_test = 0, n_frame = 0;

    // ****************************************
    // clock and instances
    // ****************************************
    always #2 clock = ~clock;
    ftt_frame_timing #(.T1_CYC(23'(T1)), .TRIG_MIN_CYC(14'(TMIN)), .CLK_HZ(28'(HZ))) DUT (
        .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
        .trigger_wait(trigger_wait), .bulk_valid(bulk_valid), .bulk_data(bulk_data),
        .bulk_last(bulk_last), .bulk_ready(bulk_ready), .event_valid(event_valid),
        .event_code(event_code), .event_ready(event_ready), .irq(irq));
    ftt_host_model host (
        .clock(clock), .fire(fire), .rude(rude), .active_low(1'b1), .width(16'(TMIN + 4)),
        .trigger_wait(trigger_wait), .trig_in(trig_in), .stall(stall), .bulk_ready(bulk_ready),
        .slow(slow), .event_valid(event_valid), .event_ready(event_ready));

    // ****************************************
    // helpers
    // ****************************************
    function automatic int exp_period(input int rate);
        return HZ / rate;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        rd(a, d);
        check(what, d, exp);
    endtask

    // ****************************************
    // monitors
    // ****************************************
    // word order, frame length, frame spacing and event counts
    always @(posedge clock) begin
        cyc <= cyc + 1;
        stall <= stall_en && ($random(seed) % 4 == 0);
        if (bulk_valid && bulk_ready) begin
            check("bulk_idx", 32'(bulk_data[15:0]), 32'(exp_idx));
            check("bulk_last", 32'(bulk_last), 32'(exp_idx == T1 - 1));
            if (exp_idx == 0) begin
                period <= cyc - last_start;
                last_start <= cyc;
            end
            exp_idx <= (exp_idx == T1 - 1) ? 0 : exp_idx + 1;
            words <= words + 1;
        end
        if (event_valid && event_ready) begin
            n_test <= n_test + int'(event_code === `FTT_EV_TEST);
            n_frame <= n_frame + int'(event_code === `FTT_EV_FRAME);
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] d, f0;
        logic [31:0] lbl [4];
        int rate, t0, w0, nf0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        rd_chk(`FTT_A_CTRL, 32'h8, "ctrl_reset");
        rd_chk(`FTT_A_RATE, 32'h3d, "rate_reset");
        rd_chk(`FTT_A_TEST, 32'h0, "test_readback");
        rd_chk(8'h20, 32'h0, "unmapped_read");
        for (int i = 0; i < 4; i++) begin
            lbl[i] = $random(seed);
            wr(`FTT_LBL_BASE + 8'(i * 20), lbl[i]);
        end
        for (int i = 0; i < 4; i++) begin
            rd_chk(`FTT_LBL_BASE + 8'(i * 20), lbl[i], "label_word");
        end
        // two test events back to back, events disabled and a slow host
        slow <= 1'b1;
        wr(`FTT_A_TEST, $random(seed));
        wr(`FTT_A_TEST, $random(seed));
        repeat (30) @(negedge clock);
        check("test_events", 32'(n_test), 32'h2);
        slow <= 1'b0;
        // free running frames at a random rate
        rate = 40 + (($random(seed) & 32'h7fff) % 22);
        wr(`FTT_A_IEN, 32'h1);
        wr(`FTT_A_RATE, 32'(rate));
        rd_chk(`FTT_A_RATE, 32'(rate), "rate_readback");
        wr(`FTT_A_CTRL, 32'hb);
        for (int i = 0; i < 1000 && words < 3 * T1; i++) @(negedge clock);
        check("free_words", 32'(words >= 3 * T1), 32'h1);
        check("frame_period", 32'(period >= exp_period(rate) && period <= exp_period(rate) + 1), 32'h1);
        check("frame_events", 32'(n_frame > 0), 32'h1);
        check("irq_done", 32'(irq), 32'h1);
        // fast rate: ticks during a busy frame are dropped and flagged
        wr(`FTT_A_RATE, 32'hff);
        repeat (200) @(negedge clock);
        rd(`FTT_A_ISTAT, d);
        check("drop_flag", 32'(d[`FTT_I_DROP]), 32'h1);
        wr(`FTT_A_RATE, 32'(rate));
        // host stalls at random, word order must survive
        stall_en <= 1'b1;
        for (int i = 0; i < 3000 && words < 6 * T1; i++) @(negedge clock);
        check("stall_words", 32'(words >= 6 * T1), 32'h1);
        stall_en <= 1'b0;
        for (int i = 0; i < 600 && !(bulk_valid && bulk_ready && bulk_last); i++) @(negedge clock);
        wr(`FTT_A_CTRL, 32'ha);
        w0 = words;
        repeat (400) @(negedge clock);
        check("closed_stream_words", 32'(words), 32'(w0));
        wr(`FTT_A_CTRL, 32'h8);
        repeat (100) @(negedge clock);
        wr(`FTT_A_ICLR, 32'h7);
        rd_chk(`FTT_A_ISTAT, 32'h0, "istat_cleared");
        check("irq_cleared", 32'(irq), 32'h0);
        // random trigger: accepted trigger, then one during readout
        wr(`FTT_A_IEN, 32'h2);
        rd(`FTT_A_FCNT, f0);
        nf0 = n_frame;
        wr(`FTT_A_CTRL, 32'hd);
        for (int i = 0; i < 20 && trigger_wait !== 1'b1; i++) @(negedge clock);
        check("wait_armed", 32'(trigger_wait), 32'h1);
        rd_chk(`FTT_A_STAT, 32'h11, "stat_armed");
        @(posedge clock) fire <= 1'b1;
        @(posedge clock) fire <= 1'b0;
        for (int i = 0; i < TMIN + 20 && trigger_wait !== 1'b0; i++) @(negedge clock);
        t0 = cyc;
        check("wait_dropped", 32'(trigger_wait), 32'h0);
        for (int i = 0; i < T3 + 20 && bulk_valid !== 1'b1; i++) @(negedge clock);
        check("trigger_delay", 32'(cyc - t0), 32'(T3 + 1));
        rude <= 1'b1;
        @(posedge clock) fire <= 1'b1;
        @(posedge clock) fire <= 1'b0;
        for (int i = 0; i < T1 + 60 && trigger_wait !== 1'b1; i++) @(negedge clock);
        check("wait_rearmed", 32'(trigger_wait), 32'h1);
        rude <= 1'b0;
        rd(`FTT_A_ISTAT, d);
        check("refused_flag", 32'(d[`FTT_I_REJ]), 32'h1);
        rd_chk(`FTT_A_FCNT, f0 + 32'h1, "one_frame");
        check("irq_refused", 32'(irq), 32'h1);
        check("no_frame_event", 32'(n_frame), 32'(nf0));
        wr(`FTT_A_IEN, 32'h0);
        repeat (3) @(negedge clock);
        check("irq_masked", 32'(irq), 32'h0);
        conclude();
    end

    // ****************************************
    // watchdog
    // ****************************************
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
endmodule
